// *** rtl/mcsr_pkg.sv ***
package mcsr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_TWO = 6'h01;
  localparam logic [5:0] IDX_CFG_FOUR = 6'h03;
  localparam logic [5:0] IDX_USER_ZERO = 6'h1B;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  // Field positions in control_function_two
  localparam int CTRL_MUX_EN_BIT = 8;
  localparam int CTRL_GEN_EN_BIT = 9;
  // Field positions in user_config_zero
  localparam int USR_IN_DLY_LSB = 0;
  localparam int USR_OUT_DLY_LSB = 3;
  localparam int USR_SYNC_EN_BIT = 6;
  // Field position in the calibration register
  localparam int CFG_CAL_EN_BIT = 24;
  // Values after reset
  localparam logic [1:0] CTRL_SYNC_RESET = 2'h1;
  localparam logic [6:0] USR_ZERO_RESET = 7'h00;
  // Clock generator and sync output divider
  localparam logic [8:0] CLKGEN_PRESET = 9'h000;
  localparam logic [8:0] CLKGEN_LAST = 9'h17F;
  localparam logic [8:0] DIV_LAST = 9'h17F;
  localparam logic [8:0] DIV_HIGH_CYCLES = 9'h100;
  // Calibration sequence
  localparam logic [3:0] CAL_SYNC_LAST = 4'hF;
  localparam logic [3:0] CAL_STEP_CYCLES = 4'h8;
  localparam logic [3:0] CAL_FINISH_CYCLES = 4'h8;
  localparam int TAP_DEPTH = 8;

  typedef enum logic [1:0] {CAL_IDLE, CAL_STEP, CAL_SYNC, CAL_FINISH} mcsr_cal_type;
endpackage : mcsr_pkg

// *** rtl/mcsr_receiver.sv ***
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Sync input is routed to the clock generator for synchronization.
// - With the generator enable bit clear, the sync input is buffered onto the sync output.
// - Input delay tap is chosen by user_config_zero bits 2 to 0.
// - Edge detector pulse lasts exactly one cycle, once per sync period.
// - Sync input rising edge is sampled on the system clock rising edge.
// - Clock generator counter advances each cycle; sync pulse presets it only in the calibration sync phase.
// - Preset state lasts one cycle, then normal stepping resumes.
// - Output delay tap is chosen by user_config_zero bits 5 to 3.
// - Each delay field is codes 0 to 7, larger code means longer delay.
// - Synchronize only with sync enable bit set and sync signal present.
// - Synchronize inside calibration after its first step, for sixteen sync periods.
// - Master generates sync output at clock over 384, two thirds high.
// - Master only when generator enable and mux enable bits are both set.
module mcsr_receiver (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sync pins
  input wire logic sync_in_i,
  output logic sync_out_o,
  // Internal clock state
  output logic sync_pulse_o,
  output logic [8:0] clkgen_state_o,
  output logic cal_busy_o
);
  import mcsr_pkg::*;
  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] mcsr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : mcsr_merge
  logic [1:0] ctrl_sync;
  logic [6:0] usr_zero;
  logic cal_en;
  logic sync_s1, sync_s2, sync_s3;
  logic sync_level, edge_prev;
  logic [8:0] div_cnt;
  logic gen_level, src_level, master_on;
  mcsr_cal_type cal_state;
  logic [3:0] cal_cnt, sync_cnt;
  logic sync_done;
  logic tap_in_q;
  // Bus decode
  wire logic [5:0] bus_idx = avs_address_i[7:2];
  wire logic bus_aligned = (avs_address_i[1:0] == 2'b00);
  wire logic bus_req = avs_read_i | avs_write_i;
  wire logic bus_wr = avs_write_i & ~avs_waitrequest_o;
  wire logic hit_ctrl = bus_aligned & (bus_idx == IDX_CTRL_TWO);
  wire logic hit_cfg = bus_aligned & (bus_idx == IDX_CFG_FOUR);
  wire logic hit_usr = bus_aligned & (bus_idx == IDX_USER_ZERO);
  wire logic hit_stat = bus_aligned & (bus_idx == IDX_STATUS);
  wire logic [31:0] ctrl_word = {22'h00_0000, ctrl_sync, 8'h00};
  wire logic [31:0] cfg_word = {7'h00, cal_en, 24'h00_0000};
  wire logic [31:0] usr_word = {25'h000_0000, usr_zero};
  wire logic [31:0] stat_word = {19'h0_0000, master_on, sync_level, sync_done, cal_busy_o, clkgen_state_o};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_cfg ? cfg_word : hit_usr ? usr_word :
                             hit_stat ? stat_word : 32'h0000_0000;
  wire logic [31:0] ctrl_new = mcsr_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] cfg_new = mcsr_merge(cfg_word, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] usr_new = mcsr_merge(usr_word, avs_writedata_i, avs_byteenable_i);
  wire logic gen_en = ctrl_sync[CTRL_GEN_EN_BIT-8];
  wire logic mux_en = ctrl_sync[CTRL_MUX_EN_BIT-8];
  wire logic sync_en = usr_zero[USR_SYNC_EN_BIT];
  wire logic [2:0] in_dly = usr_zero[USR_IN_DLY_LSB +: 3];
  wire logic [2:0] out_dly = usr_zero[USR_OUT_DLY_LSB +: 3];
  assign master_on = gen_en & mux_en;
  wire logic preset_hit = sync_pulse_o & sync_en & (cal_state == CAL_SYNC);
  wire logic cal_done = (cal_state == CAL_FINISH) & (cal_cnt == CAL_FINISH_CYCLES - 4'h1);
  // Bus handshake: one wait cycle, then a single answer cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (bus_req & avs_waitrequest_o) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end
  // Writable registers; unmapped writes are dropped
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_sync <= CTRL_SYNC_RESET;
      usr_zero <= USR_ZERO_RESET;
      cal_en <= 1'b0;
    end else if (ce_i) begin
      if (bus_wr & hit_ctrl) begin
        ctrl_sync <= ctrl_new[CTRL_GEN_EN_BIT:CTRL_MUX_EN_BIT];
      end
      if (bus_wr & hit_usr) begin
        usr_zero <= usr_new[6:0];
      end
      // Software set wins over the self-clear at the end
      if (bus_wr & hit_cfg) begin
        cal_en <= cfg_new[CFG_CAL_EN_BIT];
      end else if (cal_done) begin
        cal_en <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      sync_level <= 1'b0;
    end else if (ce_i) begin
      sync_s1 <= sync_in_i;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      if (sync_s2 == sync_s3) begin
        sync_level <= sync_s3;
      end
    end
  end

  mcsr_tap_delay u_in_tap (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(sync_level),
    .sel_i(in_dly),
    .q_o(tap_in_q)
  );
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      edge_prev <= 1'b0;
      sync_pulse_o <= 1'b0;
    end else if (ce_i) begin
      edge_prev <= tap_in_q;
      sync_pulse_o <= tap_in_q & ~edge_prev;
    end
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clkgen_state_o <= CLKGEN_PRESET;
    end else if (ce_i) begin
      if (preset_hit) begin
        clkgen_state_o <= CLKGEN_PRESET;
      end else if (clkgen_state_o == CLKGEN_LAST) begin
        clkgen_state_o <= 9'h000;
      end else begin
        clkgen_state_o <= clkgen_state_o + 9'h001;
      end
    end
  end

  // calibration sequence with a sync pause
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_state <= CAL_IDLE;
      cal_cnt <= 4'h0;
      sync_cnt <= 4'h0;
      sync_done <= 1'b0;
      cal_busy_o <= 1'b0;
    end else if (ce_i) begin
      cal_busy_o <= (cal_state != CAL_IDLE);
      case (cal_state)
        CAL_IDLE: begin
          cal_cnt <= 4'h0;
          sync_cnt <= 4'h0;
          if (cal_en) begin
            sync_done <= 1'b0;
            cal_state <= CAL_STEP;
          end
        end
        CAL_STEP: begin
          cal_cnt <= cal_cnt + 4'h1;
          if (cal_cnt == CAL_STEP_CYCLES - 4'h1) begin
            cal_cnt <= 4'h0;
            cal_state <= sync_en ? CAL_SYNC : CAL_FINISH;
          end
        end
        CAL_SYNC: begin
          // stalls here while no sync signal arrives
          if (preset_hit) begin
            sync_cnt <= sync_cnt + 4'h1;
            if (sync_cnt == CAL_SYNC_LAST) begin
              sync_done <= 1'b1;
              cal_state <= CAL_FINISH;
            end
          end
        end
        CAL_FINISH: begin
          cal_cnt <= cal_cnt + 4'h1;
          if (cal_done) begin
            cal_state <= CAL_IDLE;
          end
        end
        default: begin
          cal_state <= CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt <= 9'h000;
      gen_level <= 1'b0;
    end else if (ce_i) begin
      div_cnt <= (div_cnt == DIV_LAST) ? 9'h000 : div_cnt + 9'h001;
      gen_level <= (div_cnt < DIV_HIGH_CYCLES);
    end
  end

  // output source: generator, buffered input, or off
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_level <= 1'b0;
    end else if (ce_i) begin
      src_level <= master_on ? gen_level : (~gen_en & sync_level);
    end
  end

  // output delay tap drives the pin
  mcsr_tap_delay u_out_tap (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(src_level),
    .sel_i(out_dly),
    .q_o(sync_out_o)
  );
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_preset;
    ce_i && preset_hit;
  endsequence
  sequence s_leave_preset;
    ce_i && clkgen_state_o == CLKGEN_PRESET && !preset_hit;
  endsequence
  property p_pulse_one;
    sync_pulse_o && ce_i |=> !sync_pulse_o;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("sync pulse longer than one cycle");
  property p_edge;
    ce_i && tap_in_q && !edge_prev |=> sync_pulse_o;
  endproperty
  a_edge: assert property (p_edge) else $error("rising edge gave no pulse");
  property p_preset;
    s_preset |=> clkgen_state_o == CLKGEN_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("sync pulse did not preset counter");
  property p_advance;
    s_leave_preset |=> clkgen_state_o == CLKGEN_PRESET + 9'h001;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not resume after preset");
  property p_gate;
    ce_i && !(sync_en && cal_state == CAL_SYNC) && clkgen_state_o != CLKGEN_LAST |=> clkgen_state_o != CLKGEN_PRESET;
  endproperty
  a_gate: assert property (p_gate) else $error("preset outside enabled sync phase");
  property p_cal_sync;
    s_preset ##0 sync_cnt == CAL_SYNC_LAST |=> cal_state == CAL_FINISH && sync_done;
  endproperty
  a_cal_sync: assert property (p_cal_sync) else $error("sync phase did not end after sixteen");
  property p_duty;
    ce_i |=> gen_level == ($past(div_cnt) < DIV_HIGH_CYCLES);
  endproperty
  a_duty: assert property (p_duty) else $error("sync generator duty wrong");
  property p_source;
    ce_i && !gen_en |=> src_level == $past(sync_level);
  endproperty
  a_source: assert property (p_source) else $error("slave did not buffer sync input");
  property p_master;
    ce_i && master_on |=> src_level == $past(gen_level);
  endproperty
  a_master: assert property (p_master) else $error("master did not drive generator");
endmodule : mcsr_receiver

// *** rtl/mcsr_tap_delay.sv ***
`timescale 1ns/1ps
module mcsr_tap_delay (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Data and tap select
  input wire logic d_i,
  input wire logic [2:0] sel_i,
  output logic q_o
);
  import mcsr_pkg::*;

  logic [TAP_DEPTH-1:0] stage;
  wire logic tap_pick = stage[sel_i];

  // Shift line with a selected tap, code 0 shortest
  // one cycle per code
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage <= '0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      stage <= {stage[TAP_DEPTH-2:0], d_i};
      q_o <= tap_pick;
    end
  end
endmodule : mcsr_tap_delay

// *** tb/mcsr_sync_source.sv ***
`timescale 1ns/1ps
module mcsr_sync_source (
  // Clock and control
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic loop_i,
  input wire logic [7:0] half_i,
  // Sync lines
  input wire logic back_i,
  output logic sync_o
);
  logic gen = 1'b0;
  int cnt = 0;
  // one aligned line on the shared clock
  always_ff @(posedge clk_sys_i) begin
    cnt <= (!run_i || cnt >= half_i - 1) ? 0 : cnt + 1;
    gen <= run_i && ((cnt >= half_i - 1) ? !gen : gen);
  end
  // master output returns through the same path
  assign sync_o = loop_i ? back_i : gen;
endmodule : mcsr_sync_source

// *** tb/test_multichip_sync_receiver.sv ***
`timescale 1ns/1ps
module test_multichip_sync_receiver;
  import mcsr_pkg::*;
  logic clk = 0, rst = 1, ce = 1, rd_r = 0, wr_r = 0, run = 0, loop = 0;
  logic [7:0] adr = 8'h00, half = 8'h14;
  logic [31:0] wdat = 32'h0000_0000, rdat, rdo;
  logic wait_o, sin, sout, pulse, busy, alt0 = 0, p_pulse = 0, p_sin = 0, p_out = 0;
  logic [8:0] st;
  int error_cnt = 0, n_compared = 0, cyc = 0, presets = 0, forced = 0, t_rise = 0;
  int lat_in = 0, lat_out = 0, hi = 0, lo = 0, last_hi = 0, last_lo = 0, b_in, b_out, exp_st = -1;

  // Clock, device and sync source
  initial forever #10 clk = ~clk;
  mcsr_receiver u_mcsr_receiver (.clk_sys_i(clk), .sys_rst_i(rst), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o), .sync_in_i(sin), .sync_out_o(sout),
    .sync_pulse_o(pulse), .clkgen_state_o(st), .cal_busy_o(busy));
  mcsr_sync_source u_mcsr_sync_source (.clk_sys_i(clk), .run_i(run), .loop_i(loop), .half_i(half),
    .back_i(sout), .sync_o(sin));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr_r <= w;
    rd_r <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0);
    rdat = rdo;
    wr_r <= 0;
    rd_r <= 0;
    // Answer comes one cycle after the request is taken
    check("bus wait", n, 2);
  endtask : bus

  // Verdict
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Reference model of counter, pulse and sync timing
  always @(posedge clk) begin
    cyc++;
    if (rst) begin
      exp_st = -1;
    end else begin
      // step each cycle, preset only after a pulse
      if (exp_st >= 0 && !(alt0 && st === 9'h000)) check("clkgen", st, exp_st);
      if (alt0 && st === 9'h000 && busy) presets++;
      if (alt0 && st === 9'h000 && exp_st != 0) forced++;
      if (pulse && p_pulse) check("pulse width", 2, 1);
      if (sin && !p_sin) t_rise = cyc;
      if (pulse && !p_pulse) lat_in = cyc - t_rise;
      if (sout && !p_out) begin
        lat_out = cyc - t_rise;
        last_lo = lo;
        lo = 0;
      end
      if (!sout && p_out) begin
        last_hi = hi;
        hi = 0;
      end
      if (sout) hi++;
      else lo++;
      exp_st = !ce ? st : (st == CLKGEN_LAST ? 0 : st + 1);
      alt0 = ce && pulse;
    end
    p_pulse = pulse;
    p_sin = sin;
    p_out = sout;
  end

  // Test sequence
  initial begin
    int v;
    void'($urandom(70164));
    repeat (10) @(posedge clk);
    rst <= 0;
    bus(0, 8'h04, 0); check("ctrl reset", rdat, 32'h0000_0100);
    bus(1, 8'h6D, 32'h0000_007F);
    bus(1, 8'h10, 32'h0000_007F);
    bus(0, 8'h6C, 0); check("user reset", rdat, 0);
    bus(0, 8'h10, 0); check("unmapped", rdat, 0);
    v = $urandom % 128;
    bus(1, 8'h6C, v);
    bus(0, 8'h6C, 0); check("user rw", rdat, v);
    // Random clock enable gaps
    repeat (60) begin
      @(posedge clk);
      ce <= ($urandom % 3) != 0;
    end
    ce <= 1;
    // Slave mode: buffered output and both taps per code
    bus(1, 8'h04, 0);
    half <= 8'(12 + $urandom % 8);
    run <= 1;
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'h6C, i * 9);
      repeat (100) @(posedge clk);
      if (i == 0) begin
        b_in = lat_in;
        b_out = lat_out;
      end
      check("in delay", lat_in - b_in, i);
      check("out delay", lat_out - b_out, i);
    end
    check("idle presets", forced, 0);
    // Master generator, then the generator enable alone
    bus(1, 8'h04, 32'h0000_0300);
    repeat (900) @(posedge clk);
    check("sync high", last_hi, 256);
    check("sync low", last_lo, 128);
    bus(1, 8'h04, 32'h0000_0200);
    repeat (410) @(posedge clk);
    check("gated out", lo >= 390, 1);
    // Calibration without and with sync, output looped back
    bus(1, 8'h04, 32'h0000_0300);
    loop <= 1;
    for (int e = 0; e < 2; e++) begin
      bus(1, 8'h6C, e * 64);
      presets = 0;
      bus(1, 8'h0C, 32'h0100_0000);
      repeat (4) @(posedge clk);
      check("cal busy", busy, 1);
      for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clk);
      check("presets", presets, e * 16);
      bus(0, 8'h0C, 0); check("cal clear", rdat & 32'h0100_0000, 0);
    end
    bus(0, 8'h80, 0); check("status", rdat & 32'h0000_1400, 32'h0000_1400);
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    check("timeout", 1, 0);
    stop_test();
  end
endmodule : test_multichip_sync_receiver
